// ==== verilog/hbp_consts.svh ====
/*
 * Constants of the pseudo-SRAM host bus port: strap codes, lane masks,
 * reset values and the strap settling count.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH

// ----------------------------------------------------------------
// Width strap codes
// ----------------------------------------------------------------
`define HBP_WIDTH_32     2'h0
`define HBP_WIDTH_16     2'h1
`define HBP_WIDTH_8      2'h2

// ----------------------------------------------------------------
// Byte order codes, first strap in the high bit
// ----------------------------------------------------------------
`define HBP_ORDER_BIG    2'h0
`define HBP_ORDER_HSWAP  2'h1
`define HBP_ORDER_WSWAP  2'h2
`define HBP_ORDER_LITTLE 2'h3

// ----------------------------------------------------------------
// Host lanes in use per width
// ----------------------------------------------------------------
`define HBP_LANES_32     4'hf
`define HBP_LANES_16     4'h3
`define HBP_LANES_8      4'h1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define HBP_DATA_RST     32'h0000_0000
`define HBP_ADDR_RST     10'h000
`define HBP_STRAP_WAIT   2'h2

`endif

// ==== verilog/hbp_pkg.sv ====
/*
 * Types of the pseudo-SRAM host bus port.
 * Assumes nothing of its surroundings.
 */
package hbp_pkg;

    // ----------------------------------------------------------------
    // Access sequencer, Gray along strap -> idle -> access -> done
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_STRAP  = 2'h0,
        ST_IDLE   = 2'h1,
        ST_ACCESS = 2'h3,
        ST_DONE   = 2'h2
    } seq_state_e;

    typedef logic [1:0] lane_t;

endpackage

// ==== verilog/host_clock_capture.sv ====
/*
 * Address capture on the host bus clock for synchronous bus timing.
 * Assumes host pins are synchronous to host_bus_clock and that the
 * clock may stop between cycles.
 */
`timescale 1ns/10ps
`include "hbp_consts.svh"

module host_clock_capture (
    input  wire logic       host_bus_clock,
    input  wire logic       rst,
    input  wire logic       cs_n,
    input  wire logic       wr_n,
    input  wire logic [9:0] addr,
    output logic      [9:0] link_addr,
    output logic            link_wr,
    output logic            link_tog
);

    // ----------------------------------------------------------------
    // Capture state
    // ----------------------------------------------------------------
    logic       in_cycle;
    logic       next_in_cycle;
    logic [9:0] next_link_addr;
    logic       next_link_wr;
    logic       next_link_tog;

    always_comb begin
        next_in_cycle  = !cs_n;
        next_link_addr = link_addr;
        next_link_wr   = link_wr;
        next_link_tog  = link_tog;
        // First edge with select low only; address then held by host
        if (!cs_n && !in_cycle) begin
            next_link_addr = addr;
            next_link_wr   = !wr_n;
            next_link_tog  = !link_tog;
        end
    end

    always_ff @(posedge host_bus_clock or posedge rst) begin
        if (rst) begin
            in_cycle  <= 1'b0;
            link_addr <= `HBP_ADDR_RST;
            link_wr   <= 1'b0;
            link_tog  <= 1'b0;
        end else begin
            in_cycle  <= next_in_cycle;
            link_addr <= next_link_addr;
            link_wr   <= next_link_wr;
            link_tog  <= next_link_tog;
        end
    end

endmodule // host_clock_capture

// ==== verilog/pseudo_sram_host_bus_port.sv ====
/*
 * Pseudo-SRAM host bus port: strap decode, address capture in both bus
 * timings, lane steering, stall, interrupt and wake pins.
 * Assumes a register file on clk answering reg_req with reg_ready.
 */
// Summary of operation
// - Sync timing: capture on first bus-clock edge
// - Async timing: capture once select fall synchronised
// - Drop low address bits per bus width
// - Hardware reset floats outputs, aborts, reinitialises
// - Drive data only while output gate low
// - Gate high keeps data drivers off
// - Stall until data can be supplied or taken
// - Stall level follows polarity strap
// - Interrupt pin pulled low on event
// - Wake pin pulled low on wake event
// - Timing straps decode mode, clock, polarity
// - Byte-order straps select lane ordering
// - Width straps select 32, 16, 8 bits
`timescale 1ns/10ps
`include "hbp_consts.svh"

module pseudo_sram_host_bus_port (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        host_bus_clock,
    input  wire logic        hw_reset_n,
    input  wire logic        cs_n,
    input  wire logic        wr_n,
    input  wire logic        oe_n,
    input  wire logic [9:0]  addr,
    input  wire logic [31:0] data_in,
    output logic      [31:0] data_out,
    output logic      [31:0] data_oe_n,
    output logic             stall_out,
    output logic             stall_oe_n,
    output logic             irq_n,
    output logic             irq_n_oe_n,
    output logic             wake_event_n,
    output logic             wake_event_n_oe_n,
    input  wire logic        host_timing_strap,
    input  wire logic        sysclk_source_strap,
    input  wire logic        stall_polarity_strap,
    input  wire logic        byte_order_strap0,
    input  wire logic        byte_order_strap1,
    input  wire logic [1:0]  host_width_strap,
    input  wire logic        irq_event,
    input  wire logic        wake_event,
    output logic             reg_req,
    output logic             reg_write,
    output logic      [7:0]  reg_addr,
    output logic      [3:0]  reg_byte_en,
    output logic      [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_ready
);

    // ----------------------------------------------------------------
    // Reset: either source asserts at once, release on clk
    // ----------------------------------------------------------------
    logic [1:0] rst_chain;
    logic       rst;

    always_ff @(posedge clk or posedge sys_rst or negedge hw_reset_n) begin
        if (sys_rst || !hw_reset_n) begin
            rst_chain <= 2'h3;
        end else begin
            rst_chain <= {rst_chain[0], 1'b0};
        end
    end
    assign rst = rst_chain[1];

    // ----------------------------------------------------------------
    // Host clock side
    // ----------------------------------------------------------------
    logic [9:0] link_addr;
    logic       link_wr;
    logic       link_tog;

    host_clock_capture host_clock_capture_inst (
        .host_bus_clock (host_bus_clock),
        .rst            (rst),
        .cs_n           (cs_n),
        .wr_n           (wr_n),
        .addr           (addr),
        .link_addr      (link_addr),
        .link_wr        (link_wr),
        .link_tog       (link_tog)
    );

    // ----------------------------------------------------------------
    // Pin synchronisers, first stage read only by the second
    // ----------------------------------------------------------------
    localparam int SYNC_W = 10 + 32 + 4 + 7;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic              tog_c;
    logic [9:0]        addr_s;
    logic [31:0]       data_s;
    logic              cs_s;
    logic              wr_s;
    logic              oe_s;
    logic              tog_s;
    logic [6:0]        strap_s;
    logic              cs_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a  <= '1;
            sync_b  <= '1;
            tog_c   <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            sync_a  <= {addr, data_in, cs_n, wr_n, oe_n, link_tog, host_timing_strap,
                        sysclk_source_strap, stall_polarity_strap, byte_order_strap0,
                        byte_order_strap1, host_width_strap};
            sync_b  <= sync_a;
            tog_c   <= tog_s;
            cs_prev <= cs_s;
        end
    end
    assign {addr_s, data_s, cs_s, wr_s, oe_s, tog_s, strap_s} = sync_b;

    // ----------------------------------------------------------------
    // Lane steering helper
    // ----------------------------------------------------------------
    function automatic hbp_pkg::lane_t host_lane(input logic [1:0] width,
                                                 input logic [1:0] order,
                                                 input logic [1:0] i);
        logic swap;
        swap = (order == `HBP_ORDER_HSWAP) || (order == `HBP_ORDER_LITTLE);
        if (width == `HBP_WIDTH_8) begin
            host_lane = 2'h0;
        end else if (width == `HBP_WIDTH_16) begin
            host_lane = {1'b0, i[0] ^ swap};
        end else begin
            unique case (order)
                `HBP_ORDER_BIG:   host_lane = i;
                `HBP_ORDER_HSWAP: host_lane = i ^ 2'h1;
                `HBP_ORDER_WSWAP: host_lane = i ^ 2'h2;
                `HBP_ORDER_LITTLE: host_lane = ~i;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    hbp_pkg::seq_state_e state;
    hbp_pkg::seq_state_e next_state;
    logic [1:0]  strap_cnt, next_strap_cnt;
    logic        async_mode, next_async_mode;
    logic        stall_pol, next_stall_pol;
    logic [1:0]  order, next_order;
    logic [1:0]  width, next_width;
    logic        reading, next_reading;
    logic        stall_act;
    logic        next_stall_out;
    logic        next_reg_write;
    logic [7:0]  next_reg_addr;
    logic [3:0]  next_reg_byte_en;
    logic [31:0] next_reg_wdata;
    logic [31:0] next_data_out;
    logic [3:0]  lanes;
    logic        start;
    logic [9:0]  start_addr;
    logic        start_wr;

    assign lanes = (width == `HBP_WIDTH_8)  ? `HBP_LANES_8 :
                   (width == `HBP_WIDTH_16) ? `HBP_LANES_16 : `HBP_LANES_32;
    assign start      = async_mode ? (cs_prev && !cs_s) : (tog_s != tog_c);
    assign start_addr = async_mode ? addr_s : link_addr;
    assign start_wr   = async_mode ? !wr_s : link_wr;
    assign stall_act  = !cs_s && (state != hbp_pkg::ST_DONE);
    assign reg_req    = (state == hbp_pkg::ST_ACCESS);

    always_comb begin
        next_state       = state;
        next_strap_cnt   = strap_cnt;
        next_async_mode  = async_mode;
        next_stall_pol   = stall_pol;
        next_order       = order;
        next_width       = width;
        next_reading     = reading;
        next_reg_write   = reg_write;
        next_reg_addr    = reg_addr;
        next_reg_byte_en = reg_byte_en;
        next_reg_wdata   = reg_wdata;
        next_data_out    = data_out;
        next_stall_out   = stall_pol ? stall_act : !stall_act;
        unique case (state)
            hbp_pkg::ST_STRAP: begin
                next_strap_cnt = strap_cnt + 2'h1;
                if (strap_cnt == `HBP_STRAP_WAIT) begin
                    // Reserved internal-clock sync patterns fall back to async
                    next_async_mode = strap_s[6] || strap_s[5];
                    next_stall_pol  = strap_s[4];
                    next_order      = strap_s[3:2];
                    // Reserved width treated as 32 bits
                    next_width      = (strap_s[1:0] == 2'h3) ? `HBP_WIDTH_32 : strap_s[1:0];
                    next_state      = hbp_pkg::ST_IDLE;
                end
                // Idle level ready before the pin first drives
                next_stall_out = !next_stall_pol;
            end
            hbp_pkg::ST_IDLE: begin
                if (start) begin
                    next_reg_write = start_wr;
                    next_reading   = !start_wr;
                    next_reg_addr  = start_addr[9:2];
                    unique case (width)
                        `HBP_WIDTH_8:  next_reg_byte_en = 4'h1 << start_addr[1:0];
                        `HBP_WIDTH_16: next_reg_byte_en = start_addr[1] ? 4'hc : 4'h3;
                        default:       next_reg_byte_en = 4'hf;
                    endcase
                    next_state = hbp_pkg::ST_ACCESS;
                end
            end
            hbp_pkg::ST_ACCESS: begin
                for (int i = 0; i < 4; i++) begin
                    next_reg_wdata[8*i +: 8] = data_s[8*host_lane(width, order, 2'(i)) +: 8];
                end
                if (reg_ready) begin
                    next_data_out = `HBP_DATA_RST;
                    for (int i = 0; i < 4; i++) begin
                        if (reg_byte_en[i]) begin
                            next_data_out[8*host_lane(width, order, 2'(i)) +: 8] = reg_rdata[8*i +: 8];
                        end
                    end
                    next_state = hbp_pkg::ST_DONE;
                end
            end
            hbp_pkg::ST_DONE: begin
                if (cs_s) begin
                    next_reading = 1'b0;
                    next_state   = hbp_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= hbp_pkg::ST_STRAP;
            strap_cnt   <= 2'h0;
            async_mode  <= 1'b1;
            stall_pol   <= 1'b0;
            order       <= `HBP_ORDER_BIG;
            width       <= `HBP_WIDTH_32;
            reading     <= 1'b0;
            stall_out   <= 1'b0;
            reg_write   <= 1'b0;
            reg_addr    <= 8'h00;
            reg_byte_en <= 4'h0;
            reg_wdata   <= `HBP_DATA_RST;
            data_out    <= `HBP_DATA_RST;
        end else begin
            state       <= next_state;
            strap_cnt   <= next_strap_cnt;
            async_mode  <= next_async_mode;
            stall_pol   <= next_stall_pol;
            order       <= next_order;
            width       <= next_width;
            reading     <= next_reading;
            stall_out   <= next_stall_out;
            reg_write   <= next_reg_write;
            reg_addr    <= next_reg_addr;
            reg_byte_en <= next_reg_byte_en;
            reg_wdata   <= next_reg_wdata;
            data_out    <= next_data_out;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers; gate pin acts directly so release never waits on sync
    // ----------------------------------------------------------------
    logic drive_rd;
    logic irq_hold;
    logic wake_hold;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_rd   <= 1'b0;
            irq_hold   <= 1'b0;
            wake_hold  <= 1'b0;
            stall_oe_n <= 1'b1;
        end else begin
            drive_rd   <= reading && (next_state == hbp_pkg::ST_DONE) && !oe_s;
            irq_hold   <= irq_event;
            wake_hold  <= wake_event;
            stall_oe_n <= (next_state == hbp_pkg::ST_STRAP);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            // Lanes outside the strapped width never turn on
            assign data_oe_n[8*g +: 8] = {8{!(drive_rd && !oe_n && lanes[g])}};
        end
    endgenerate

    assign irq_n             = 1'b0;
    assign irq_n_oe_n        = !irq_hold;
    assign wake_event_n      = 1'b0;
    assign wake_event_n_oe_n = !wake_hold;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_STALL_HELD: assert property (@(posedge clk) disable iff (rst)
        (state == hbp_pkg::ST_ACCESS) && $past(state == hbp_pkg::ST_ACCESS) && !$past(cs_s)
        |-> stall_out == stall_pol) else $error("stall not asserted during access");
    AST_STALL_POL: assert property (@(posedge clk) disable iff (rst)
        $past(state == hbp_pkg::ST_DONE) && (state == hbp_pkg::ST_DONE)
        |-> stall_out != stall_pol) else $error("stall level wrong after data ready");
    AST_GATE_OFF: assert property (@(posedge clk) disable iff (rst)
        oe_n |-> &data_oe_n) else $error("data driven with gate high");
    AST_READ_ONLY: assert property (@(posedge clk) disable iff (rst)
        !data_oe_n[0] |-> reading && state == hbp_pkg::ST_DONE) else $error("drive outside read");
    AST_UPPER_FLOAT: assert property (@(posedge clk) disable iff (rst)
        (width != `HBP_WIDTH_32) |-> &data_oe_n[31:16]) else $error("upper lanes driven");
    AST_BYTE_WIDTH: assert property (@(posedge clk) disable iff (rst)
        (width == `HBP_WIDTH_8) |-> &data_oe_n[15:8]) else $error("lanes 15:8 driven in 8-bit");
    AST_ASYNC_CAP: assert property (@(posedge clk) disable iff (rst)
        async_mode && state == hbp_pkg::ST_IDLE && cs_prev && !cs_s
        |=> state == hbp_pkg::ST_ACCESS && reg_addr == $past(addr_s[9:2])) else $error("async capture");
    AST_SYNC_CAP: assert property (@(posedge clk) disable iff (rst)
        !async_mode && state == hbp_pkg::ST_IDLE && tog_s != tog_c
        |=> state == hbp_pkg::ST_ACCESS && reg_addr == $past(link_addr[9:2])) else $error("sync capture");
    AST_LOW_BITS: assert property (@(posedge clk) disable iff (rst)
        state == hbp_pkg::ST_ACCESS |-> (width == `HBP_WIDTH_32) ? reg_byte_en == 4'hf
        : (width == `HBP_WIDTH_8) ? $onehot(reg_byte_en) : $countones(reg_byte_en) == 2)
        else $error("byte enables do not match width");
    AST_WRITE_FLAG: assert property (@(posedge clk) disable iff (rst)
        async_mode && state == hbp_pkg::ST_IDLE && start && !wr_s |=> reg_write) else $error("write lost");
    AST_IRQ_PIN: assert property (@(posedge clk) disable iff (rst)
        irq_event |=> !irq_n_oe_n && !irq_n) else $error("interrupt not pulled low");
    AST_WAKE_PIN: assert property (@(posedge clk) disable iff (rst)
        wake_event |=> !wake_event_n_oe_n) else $error("wake not pulled low");
    AST_RESET_FLOAT: assert property (@(posedge clk)
        rst |-> &data_oe_n && stall_oe_n && irq_n_oe_n) else $error("output driven in reset");

    COV_ASYNC_READ: cover property (@(posedge clk) disable iff (rst)
        async_mode && reading && state == hbp_pkg::ST_DONE && !data_oe_n[0]);
    COV_SYNC_WRITE: cover property (@(posedge clk) disable iff (rst)
        !async_mode && reg_write && reg_req && reg_ready);
    COV_BYTE_ACCESS: cover property (@(posedge clk) disable iff (rst)
        width == `HBP_WIDTH_8 && reg_req && reg_byte_en == 4'h8);

endmodule // pseudo_sram_host_bus_port

// ==== sim/host_model.sv ====
/*
 * Host processor model on the pseudo-SRAM pins: one access task.
 * Assumes clk for pacing; the bus clock runs only inside frames.
 */
`timescale 1ns/10ps

module host_model (
    input  wire logic        clk,
    input  wire logic        pol,
    input  wire logic        sync_mode,
    input  wire logic        stall_out,
    input  wire logic        stall_oe_n,
    input  wire logic [31:0] data_bus,
    input  wire logic [31:0] data_oe_n,
    output logic             cs_n,
    output logic             wr_n,
    output logic             oe_n,
    output logic      [9:0]  addr,
    output logic             host_drv,
    output logic      [31:0] host_wd,
    output logic             host_bus_clock
);
    logic run = 1'b0;

    initial {cs_n, wr_n, oe_n, addr, host_drv, host_wd} = {3'h7, 10'h2aa, 33'h0};

    // Stands still between frames
    always #24 host_bus_clock = run ? ~host_bus_clock : 1'b0;

    task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic [31:0] oen, output logic ok);
        int n;
        int m;
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= ~wr;
        oe_n <= wr;
        {addr, host_wd, host_drv, run} <= {a, wd, wr, sync_mode};
        for (n = 0; n < 20 && !(stall_oe_n === 1'b0 && stall_out === pol); n++) @(negedge clk);
        for (m = 0; m < 60 && stall_out === pol; m++) @(negedge clk);
        rd = data_bus;
        oen = data_oe_n;
        ok = n < 20 && m < 60;
        @(posedge clk);
        {cs_n, wr_n, oe_n} <= 3'h7;
        host_drv <= 1'b0;
        // Released address must not look held
        addr <= ~a;
        repeat (4) @(posedge clk);
        run <= 1'b0;
    endtask
endmodule // host_model

// ==== sim/tb_pseudo_sram_host_bus_port.sv ====
/*
 * Self-checking bench of the pseudo-SRAM host bus port.
 * Assumes host_model on the pins and a register file modelled here.
 */
`timescale 1ns/10ps

module tb_pseudo_sram_host_bus_port;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hw_reset_n = 1'b1;
    logic        irq_event = 1'b0;
    logic        wake_event = 1'b0;
    logic        reg_ready = 1'b0;
    logic [6:0]  strap = 7'h50;
    logic [31:0] reg_rdata = 32'h0000_0000;
    logic [31:0] junk = 32'h5a5a_a5a5;
    logic [7:0]  wcnt = 8'h00;
    logic [7:0]  dly = 8'h00;
    logic [31:0] data_bus, data_out, data_oe_n, host_wd, reg_wdata, cd;
    logic [9:0]  addr;
    logic [7:0]  reg_addr, ca;
    logic [3:0]  reg_byte_en, cb;
    logic        cs_n, wr_n, oe_n, host_drv, host_bus_clock, stall_out, stall_oe_n, irq_n, irq_n_oe_n;
    logic        wake_event_n, wake_event_n_oe_n, reg_req, reg_write, cw;
    int          error_cnt = 0;
    int          total_checks = 0;
    logic [6:0]  cfgs [8] = '{7'h50, 7'h04, 7'h78, 7'h4c, 7'h55, 7'h11, 7'h6e, 7'h52};
    logic [9:0]  adrs [8] = '{10'h2b7, 10'h155, 10'h3ff, 10'h0a6, 10'h0ce, 10'h0f1, 10'h3c3, 10'h001};

    always #25 clk = ~clk;
    always @(posedge clk) junk <= ~junk;
    // Undriven lanes show a changing pattern
    assign data_bus = (~data_oe_n & data_out) | (data_oe_n & (host_drv ? host_wd : junk));

    // ----------------------------------------------------------------
    // Register file, answers after a strap-dependent delay
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (reg_req && reg_ready) {cw, ca, cb, cd} <= {reg_write, reg_addr, reg_byte_en, reg_wdata};
        wcnt <= (reg_req && !reg_ready) ? wcnt + 8'h01 : 8'h00;
        reg_ready <= reg_req && !reg_ready && wcnt >= dly;
    end

    pseudo_sram_host_bus_port pseudo_sram_host_bus_port_inst (
        .clk, .sys_rst, .host_bus_clock, .hw_reset_n, .cs_n, .wr_n, .oe_n, .addr, .data_in(data_bus),
        .data_out, .data_oe_n, .stall_out, .stall_oe_n, .irq_n, .irq_n_oe_n, .wake_event_n, .wake_event_n_oe_n,
        .host_timing_strap(strap[6]), .sysclk_source_strap(strap[5]), .stall_polarity_strap(strap[4]),
        .byte_order_strap0(strap[3]), .byte_order_strap1(strap[2]), .host_width_strap(strap[1:0]),
        .irq_event, .wake_event, .reg_req, .reg_write, .reg_addr, .reg_byte_en, .reg_wdata, .reg_rdata, .reg_ready
    );

    host_model host_model_inst (
        .clk, .pol(strap[4]), .sync_mode(~strap[6]), .stall_out, .stall_oe_n, .data_bus, .data_oe_n,
        .cs_n, .wr_n, .oe_n, .addr, .host_drv, .host_wd, .host_bus_clock
    );

    // ----------------------------------------------------------------
    // Checking and expectations
    // ----------------------------------------------------------------
    function automatic logic [31:0] swz(input logic [31:0] d, input logic [1:0] o);
        case (o)
            2'h0: swz = d;
            2'h1: swz = {d[23:16], d[31:24], d[7:0], d[15:8]};
            2'h2: swz = {d[15:0], d[31:16]};
            default: swz = {d[7:0], d[15:8], d[23:16], d[31:24]};
        endcase
    endfunction

    function automatic logic [31:0] bm(input logic [3:0] b);
        bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask, input string m);
        total_checks++;
        if ((got & mask) !== (exp & mask)) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic run_cfg(input logic [6:0] s, input logic [9:0] a);
        logic [31:0] rd, oen, hd, rv, ex, lane;
        logic [15:0] h;
        logic [3:0]  be;
        logic        ok;
        @(posedge clk);
        {hw_reset_n, irq_event, strap, dly} <= {2'h1, s, 5'h00, s[2:0]};
        @(negedge clk);
        chk(data_oe_n, '1, '1, "data float in reset");
        chk({29'h0, stall_oe_n, irq_n_oe_n, wake_event_n_oe_n}, 32'h7, '1, "pins float");
        @(posedge clk);
        {hw_reset_n, irq_event} <= 2'h2;
        repeat (10) @(posedge clk);
        hd = {15'h4d2b, s, a};
        be = (s[1:0] == 2'h1) ? (a[1] ? 4'hc : 4'h3) : (s[1:0] == 2'h2) ? 4'h1 << a[1:0] : 4'hf;
        h = s[2] ? {hd[7:0], hd[15:8]} : hd[15:0];
        ex = (s[1:0] == 2'h1) ? {h, h} : (s[1:0] == 2'h2) ? {4{hd[7:0]}} : swz(hd, s[3:2]);
        host_model_inst.access(1'b1, a, hd, rd, oen, ok);
        chk({31'h0, ok}, 32'h1, '1, "write stall");
        if (!ok) complete_run();
        chk({23'h0, cw, ca}, {23'h0, 1'b1, a[9:2]}, '1, "write cmd");
        chk({28'h0, cb}, {28'h0, be}, '1, "byte enables");
        chk(cd, ex, bm(be), "write lanes");
        reg_rdata <= ~hd;
        rv = ~hd;
        h = a[1] ? rv[31:16] : rv[15:0];
        h = s[2] ? {h[7:0], h[15:8]} : h;
        ex = (s[1:0] == 2'h1) ? {16'h0, h} : (s[1:0] == 2'h2) ? rv >> {a[1:0], 3'h0} : swz(rv, s[3:2]);
        lane = bm((s[1:0] == 2'h1) ? 4'h3 : (s[1:0] == 2'h2) ? 4'h1 : 4'hf);
        host_model_inst.access(1'b0, a, hd, rd, oen, ok);
        chk({31'h0, ok}, 32'h1, '1, "read stall");
        if (!ok) complete_run();
        chk({31'h0, cw}, 32'h0, '1, "read cmd");
        chk(rd, ex, lane, "read lanes");
        chk(oen, ~lane, '1, "read drivers");
        @(negedge clk);
        chk(data_oe_n, '1, '1, "drivers off");
    endtask

    // Host uses async timing in six configurations and sync timing in two (7'h04, 7'h11); clock source strap set in 7'h78, 7'h6e
    // Host never asks for a PHY power-down, so the internal clock stays safe
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            run_cfg(cfgs[i], adrs[i]);
        end
        @(posedge clk);
        {irq_event, wake_event} <= 2'h3;
        repeat (2) @(negedge clk);
        chk({30'h0, irq_n_oe_n | irq_n, wake_event_n_oe_n | wake_event_n}, 32'h0, '1, "event pulled");
        @(posedge clk);
        {irq_event, wake_event} <= 2'h0;
        repeat (2) @(negedge clk);
        chk({30'h0, irq_n_oe_n, wake_event_n_oe_n}, 32'h3, '1, "event released");
        complete_run();
    end
endmodule // tb_pseudo_sram_host_bus_port
